// *** include/uart_frame_defs.svh ***
/*
  Constants of the serial port with framing check and address match.
  Assumes one clock domain; included by its bare name.
*/
// Summary of operation
// - One shift mode plus three full-duplex asynchronous modes numbered 1, 2, 3.
// - Asynchronous receiver and transmitter run together, each on its own baud tick.
// - Stop-bit checking works in all async modes, only while frame check select set.
// - With checking on, a bad stop level on any frame sets the framing error flag.
// - Framing error flag is sticky; only a software write or reset clears it.
// - With checking on, receive done rises at the stop bit, not last data bit.
// - Given address is station address with mask-zero positions as don't care.
// - Broadcast address is station address OR mask; zero positions match anything.
// - Multiprocessor enable turns on address reception, only in nine-bit modes 2, 3.
// - In nine-bit modes the received ninth bit is stored in a status bit.
// - In mode 0 receive and transmit done rise at the end of the eighth bit.
`ifndef UART_FRAME_DEFS_SVH
`define UART_FRAME_DEFS_SVH

// ----------------------------------------
// Oversampling and bit counts
// ----------------------------------------
`define OS_MID      4'h7
`define OS_LAST     4'hf
`define LAST_DATA8  4'h7
`define LAST_DATA9  4'h8
`define STOP_IDX8   4'h9
`define STOP_IDX9   4'ha
`define SHIFT_LAST  3'h7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FLAG_RST    1'b0
`define BYTE_RST    8'h00
`define LINE_IDLE   1'b1

`endif

// *** include/uf_pkg.sv ***
/*
  Types of the serial port with framing check and address match.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package uf_pkg;
  typedef enum logic [1:0] {MODE_SHIFT, MODE_UART8, MODE_UART9_FIX, MODE_UART9_VAR} mode_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum logic [0:0] {TX_IDLE, TX_SERIAL} tx_state_t;

  typedef struct packed {
    logic serial_mode_bit1;
    logic multiproc_enable;
    logic rx_enable;
    logic tx_ninth;
    logic frame_check_select;
  } serial_cfg_t;

  typedef struct packed {
    logic [7:0] station_address;
    logic [7:0] station_address_mask;
  } addr_cfg_t;
endpackage

// *** logic/addr_match.sv ***
/*
  Address recognition for multiprocessor reception: given and broadcast.
  Assumes a settled received byte; purely combinational.
*/
`timescale 1ns/1ps
module addr_match (
  input  wire logic [7:0]        rx_byte,
  input  wire uf_pkg::addr_cfg_t addr_cfg,
  output logic                   given_hit,
  output logic                   broadcast_hit,
  output logic                   addr_hit
);
  logic [7:0] broadcast;

  // Positions with care zero never reject
  function automatic logic care_match(input logic [7:0] value,
                                      input logic [7:0] pattern,
                                      input logic [7:0] care);
    care_match = ((value ^ pattern) & care) == 8'h00;
  endfunction

  always_comb begin
    broadcast     = addr_cfg.station_address | addr_cfg.station_address_mask;
    given_hit     = care_match(rx_byte, addr_cfg.station_address,
                               addr_cfg.station_address_mask);
    broadcast_hit = care_match(rx_byte, broadcast, broadcast);
    addr_hit      = given_hit | broadcast_hit;
  end
endmodule // addr_match

// *** logic/uart_frame_check_addr_match.sv ***
/*
  Serial port: shift mode 0, async modes 1-3, stop-bit check, address match.
  Assumes rx_tick/tx_tick are 16x oversample pulses and shift_tick a half-bit
  pulse, all from baud logic on clk_sys; rxd_in comes straight from a pin.
*/
`timescale 1ns/1ps
`include "uart_frame_defs.svh"
module uart_frame_check_addr_match (
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  input  wire logic                  clk_en,
  input  wire logic                  rxd_in,
  output logic                       rxd_out,
  output logic                       rxd_oe,
  output logic                       txd,
  input  wire logic                  rx_tick,
  input  wire logic                  tx_tick,
  input  wire logic                  shift_tick,
  input  wire uf_pkg::serial_cfg_t   cfg,
  input  wire uf_pkg::addr_cfg_t     addr_cfg,
  input  wire logic                  tx_start,
  input  wire logic [7:0]            tx_data,
  input  wire logic                  rx_done_clr,
  input  wire logic                  tx_done_clr,
  input  wire logic                  bit7_wr,
  input  wire logic                  bit7_wdata,
  output logic [7:0]                 rx_data,
  output logic                       received_ninth_bit,
  output logic                       receive_done_flag,
  output logic                       transmit_done_flag,
  output logic                       framing_error_flag,
  output logic                       serial_mode_bit0,
  output logic                       bit7_rd
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  uf_pkg::mode_t     mode;
  uf_pkg::rx_state_t rx_state_reg, rx_state_next;
  uf_pkg::tx_state_t tx_state_reg, tx_state_next;
  logic       rxd_meta_reg, rxd_sync_reg;
  logic [3:0] rx_os_reg, rx_os_next, rx_bit_reg, rx_bit_next;
  logic [8:0] rx_shift_reg, rx_shift_next;
  logic [3:0] tx_os_reg, tx_os_next, tx_bit_reg, tx_bit_next;
  logic [10:0] tx_shift_reg, tx_shift_next;
  logic       sh_active_reg, sh_active_next, sh_dir_rx_reg, sh_dir_rx_next;
  logic       sh_phase_reg, sh_phase_next;
  logic [2:0] sh_bit_reg, sh_bit_next;
  logic [7:0] sh_data_reg, sh_data_next;
  logic       nine, mp_active, rx_finish, stop_sample, rx_accept, sh_done, tx_stop_begin;
  logic [7:0] rx_byte;
  logic       rx_ninth, addr_hit;
  logic [7:0] rx_data_next;
  logic       rb8_next, ri_next, ti_next, fe_next, mb0_next, bit7_next;
  logic       txd_next, rxd_out_next, rxd_oe_next;

  assign mode      = uf_pkg::mode_t'({cfg.serial_mode_bit1, serial_mode_bit0});
  assign nine      = cfg.serial_mode_bit1;
  assign mp_active = cfg.multiproc_enable & nine;

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rxd_meta_reg <= `LINE_IDLE;
      rxd_sync_reg <= `LINE_IDLE;
    end else if (clk_en) begin
      rxd_meta_reg <= rxd_in;
      rxd_sync_reg <= rxd_meta_reg;
    end
  end

  // ----------------------------------------
  // Asynchronous receiver
  // ----------------------------------------
  // Bits are sampled mid-cell: the start bit realigns the counter at its middle
  always_comb begin
    rx_state_next = rx_state_reg;
    rx_os_next    = rx_tick ? rx_os_reg + 4'h1 : rx_os_reg;
    rx_bit_next   = rx_bit_reg;
    rx_shift_next = rx_shift_reg;
    rx_finish     = 1'b0;
    stop_sample   = 1'b0;
    if (mode == uf_pkg::MODE_SHIFT) begin
      rx_state_next = uf_pkg::RX_IDLE;
    end else begin
      case (rx_state_reg)
        uf_pkg::RX_IDLE: begin
          rx_os_next = 4'h0;
          if (cfg.rx_enable && !rxd_sync_reg) begin
            rx_state_next = uf_pkg::RX_START;
          end
        end
        uf_pkg::RX_START: begin
          if (rx_tick && rx_os_reg == `OS_MID) begin
            rx_os_next    = 4'h0;
            rx_bit_next   = 4'h0;
            rx_state_next = rxd_sync_reg ? uf_pkg::RX_IDLE : uf_pkg::RX_DATA;
          end
        end
        uf_pkg::RX_DATA: begin
          if (rx_tick && rx_os_reg == `OS_LAST) begin
            rx_shift_next = {rxd_sync_reg, rx_shift_reg[8:1]};
            rx_bit_next   = rx_bit_reg + 4'h1;
            if (rx_bit_reg == (nine ? `LAST_DATA9 : `LAST_DATA8)) begin
              rx_state_next = uf_pkg::RX_STOP;
              rx_finish     = !cfg.frame_check_select;
            end
          end
        end
        uf_pkg::RX_STOP: begin
          if (rx_tick && rx_os_reg == `OS_LAST) begin
            stop_sample   = 1'b1;
            rx_finish     = cfg.frame_check_select;
            rx_state_next = uf_pkg::RX_IDLE;
          end
        end
        default: rx_state_next = uf_pkg::RX_IDLE;
      endcase
    end
    rx_byte  = nine ? rx_shift_next[7:0] : rx_shift_next[8:1];
    rx_ninth = rx_shift_next[8];
    // Data frames are dropped too while address filtering is on
    rx_accept = rx_finish & (!mp_active | (rx_ninth & addr_hit));
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_state_reg <= uf_pkg::RX_IDLE;
      rx_os_reg    <= 4'h0;
      rx_bit_reg   <= 4'h0;
      rx_shift_reg <= 9'h000;
    end else if (clk_en) begin
      rx_state_reg <= rx_state_next;
      rx_os_reg    <= rx_os_next;
      rx_bit_reg   <= rx_bit_next;
      rx_shift_reg <= rx_shift_next;
    end
  end

  addr_match u_addr_match (
    .rx_byte       (rx_byte),
    .addr_cfg      (addr_cfg),
    .given_hit     (),
    .broadcast_hit (),
    .addr_hit      (addr_hit)
  );

  // ----------------------------------------
  // Mode 0 shift engine
  // ----------------------------------------
  // Half-duplex: the clock goes out on txd, data on the two-way rxd pin
  always_comb begin
    sh_active_next = sh_active_reg;
    sh_dir_rx_next = sh_dir_rx_reg;
    sh_phase_next  = sh_phase_reg;
    sh_bit_next    = sh_bit_reg;
    sh_data_next   = sh_data_reg;
    sh_done        = 1'b0;
    if (!sh_active_reg) begin
      sh_phase_next = 1'b0;
      sh_bit_next   = 3'h0;
      if (mode == uf_pkg::MODE_SHIFT && tx_start) begin
        sh_active_next = 1'b1;
        sh_dir_rx_next = 1'b0;
        sh_data_next   = tx_data;
      end else if (mode == uf_pkg::MODE_SHIFT && cfg.rx_enable && !receive_done_flag) begin
        sh_active_next = 1'b1;
        sh_dir_rx_next = 1'b1;
      end
    end else if (shift_tick) begin
      sh_phase_next = !sh_phase_reg;
      if (sh_phase_reg) begin
        sh_data_next = sh_dir_rx_reg ? {rxd_sync_reg, sh_data_reg[7:1]}
                                     : {1'b0, sh_data_reg[7:1]};
        sh_bit_next  = sh_bit_reg + 3'h1;
        if (sh_bit_reg == `SHIFT_LAST) begin
          sh_active_next = 1'b0;
          sh_done        = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sh_active_reg <= 1'b0;
      sh_dir_rx_reg <= 1'b0;
      sh_phase_reg  <= 1'b0;
      sh_bit_reg    <= 3'h0;
      sh_data_reg   <= `BYTE_RST;
    end else if (clk_en) begin
      sh_active_reg <= sh_active_next;
      sh_dir_rx_reg <= sh_dir_rx_next;
      sh_phase_reg  <= sh_phase_next;
      sh_bit_reg    <= sh_bit_next;
      sh_data_reg   <= sh_data_next;
    end
  end

  // ----------------------------------------
  // Asynchronous transmitter
  // ----------------------------------------
  // Own tick and state, so it runs beside the receiver at another rate
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_os_next    = tx_os_reg;
    tx_bit_next   = tx_bit_reg;
    tx_shift_next = tx_shift_reg;
    tx_stop_begin = 1'b0;
    case (tx_state_reg)
      uf_pkg::TX_IDLE: begin
        if (tx_start && mode != uf_pkg::MODE_SHIFT) begin
          tx_state_next = uf_pkg::TX_SERIAL;
          tx_os_next    = 4'h0;
          tx_bit_next   = 4'h0;
          tx_shift_next = nine ? {1'b1, cfg.tx_ninth, tx_data, 1'b0}
                               : {2'b11, tx_data, 1'b0};
        end
      end
      uf_pkg::TX_SERIAL: begin
        if (tx_tick) begin
          tx_os_next = tx_os_reg + 4'h1;
          if (tx_os_reg == `OS_LAST) begin
            tx_shift_next = {1'b1, tx_shift_reg[10:1]};
            tx_bit_next   = tx_bit_reg + 4'h1;
            tx_stop_begin = tx_bit_next == (nine ? `STOP_IDX9 : `STOP_IDX8);
            if (tx_bit_reg == (nine ? `STOP_IDX9 : `STOP_IDX8)) begin
              tx_state_next = uf_pkg::TX_IDLE;
            end
          end
        end
      end
      default: tx_state_next = uf_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_reg <= uf_pkg::TX_IDLE;
      tx_os_reg    <= 4'h0;
      tx_bit_reg   <= 4'h0;
      tx_shift_reg <= 11'h7ff;
    end else if (clk_en) begin
      tx_state_reg <= tx_state_next;
      tx_os_reg    <= tx_os_next;
      tx_bit_reg   <= tx_bit_next;
      tx_shift_reg <= tx_shift_next;
    end
  end

  // ----------------------------------------
  // Flags and pins
  // ----------------------------------------
  // Hardware set beats a clear arriving in the same cycle
  always_comb begin
    rx_data_next = rx_data;
    rb8_next     = received_ninth_bit;
    ri_next      = rx_done_clr ? 1'b0 : receive_done_flag;
    ti_next      = tx_done_clr ? 1'b0 : transmit_done_flag;
    fe_next      = framing_error_flag;
    mb0_next     = serial_mode_bit0;
    if (rx_accept) begin
      rx_data_next = rx_byte;
      ri_next      = 1'b1;
      if (nine) begin
        rb8_next = rx_ninth;
      end
    end
    if (sh_done && sh_dir_rx_reg) begin
      rx_data_next = sh_data_next;
      ri_next      = 1'b1;
    end
    if (tx_stop_begin || (sh_done && !sh_dir_rx_reg)) begin
      ti_next = 1'b1;
    end
    if (bit7_wr && cfg.frame_check_select) begin
      fe_next = bit7_wdata;
    end
    if (bit7_wr && !cfg.frame_check_select) begin
      mb0_next = bit7_wdata;
    end
    if (stop_sample && cfg.frame_check_select && !rxd_sync_reg) begin
      fe_next = 1'b1;
    end
    bit7_next    = cfg.frame_check_select ? fe_next : mb0_next;
    rxd_oe_next  = sh_active_next && !sh_dir_rx_next;
    rxd_out_next = rxd_oe_next ? sh_data_next[0] : 1'b0;
    if (sh_active_next) begin
      txd_next = sh_phase_next;
    end else if (tx_state_next == uf_pkg::TX_SERIAL) begin
      txd_next = tx_shift_next[0];
    end else begin
      txd_next = `LINE_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_data            <= `BYTE_RST;
      received_ninth_bit <= `FLAG_RST;
      receive_done_flag  <= `FLAG_RST;
      transmit_done_flag <= `FLAG_RST;
      framing_error_flag <= `FLAG_RST;
      serial_mode_bit0   <= `FLAG_RST;
      bit7_rd            <= `FLAG_RST;
      txd                <= `LINE_IDLE;
      rxd_out            <= 1'b0;
      rxd_oe             <= 1'b0;
    end else if (clk_en) begin
      rx_data            <= rx_data_next;
      received_ninth_bit <= rb8_next;
      receive_done_flag  <= ri_next;
      transmit_done_flag <= ti_next;
      framing_error_flag <= fe_next;
      serial_mode_bit0   <= mb0_next;
      bit7_rd            <= bit7_next;
      txd                <= txd_next;
      rxd_out            <= rxd_out_next;
      rxd_oe             <= rxd_oe_next;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  fe_sticky_a: assert property (framing_error_flag && !(bit7_wr && cfg.frame_check_select)
    |=> framing_error_flag) else $error("framing error flag lost");
  fe_set_a: assert property (clk_en && stop_sample && cfg.frame_check_select && !rxd_sync_reg
    |=> framing_error_flag) else $error("bad stop bit not flagged");
  fe_off_a: assert property (!framing_error_flag && !cfg.frame_check_select
    |=> !framing_error_flag) else $error("framing error set while check off");
  ri_stop_a: assert property (clk_en && rx_finish && cfg.frame_check_select
    |-> rx_state_reg == uf_pkg::RX_STOP) else $error("receive done not at stop");
  ri_data_a: assert property (clk_en && rx_finish && !cfg.frame_check_select
    |-> rx_state_reg == uf_pkg::RX_DATA) else $error("receive done not at data");
  addr_drop_a: assert property (clk_en && rx_finish && mp_active && !(rx_ninth && addr_hit)
    && !receive_done_flag && !sh_done |=> !receive_done_flag)
    else $error("unmatched frame accepted");
  ninth_bit_a: assert property (clk_en && rx_accept && nine
    |=> received_ninth_bit == $past(rx_ninth)) else $error("ninth bit not stored");
  mode0_done_a: assert property (clk_en && sh_done
    |=> (sh_dir_rx_reg ? receive_done_flag : transmit_done_flag))
    else $error("mode 0 done flag missing");
  bit7_share_a: assert property (clk_en && bit7_wr && !cfg.frame_check_select
    |=> serial_mode_bit0 == $past(bit7_wdata) ##0 bit7_rd == serial_mode_bit0)
    else $error("mode bit 0 write lost");
  tx_start_a: assert property (clk_en && tx_start && tx_state_reg == uf_pkg::TX_IDLE
    && mode != uf_pkg::MODE_SHIFT |=> tx_state_reg == uf_pkg::TX_SERIAL ##1 !txd [*1])
    else $error("transmit not started");

  fe_seen_c: cover property (clk_en && stop_sample && cfg.frame_check_select && !rxd_sync_reg);
  addr_ok_c: cover property (clk_en && rx_accept && mp_active);
  mode0_c:   cover property (clk_en && sh_done);
  duplex_c:  cover property (tx_state_reg == uf_pkg::TX_SERIAL && rx_state_reg == uf_pkg::RX_DATA);
endmodule // uart_frame_check_addr_match

// *** verification/serial_node_model.sv ***
/*
  Remote serial node: sends async frames on the receive pin and
  captures frames from the transmit pin, both timed by the 16x ticks.
  Assumes ticks are one-cycle pulses on clk_sys; tasks are called by the bench.
*/
`timescale 1ns/1ps
module serial_node_model (
  input  wire logic clk_sys,
  input  wire logic rx_tick,
  input  wire logic tx_tick,
  input  wire logic txd,
  output logic      node_rxd
);
  initial node_rxd = 1'b1;

  task automatic wait_rx(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      while (rx_tick !== 1'b1) @(posedge clk_sys);
    end
    @(negedge clk_sys);
  endtask

  task automatic wait_tx(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      while (tx_tick !== 1'b1) @(posedge clk_sys);
    end
  endtask

  // ----------------------------------------
  // Sending
  // ----------------------------------------
  task automatic send_bits(input logic [8:0] d, input int nbits);
    node_rxd = 1'b0;
    wait_rx(16);
    for (int i = 0; i < nbits; i++) begin
      node_rxd = d[i];
      wait_rx(16);
    end
  endtask

  // Bad stop is cut short; a false start it leaves is dropped at mid-start
  task automatic send_stop(input logic s);
    node_rxd = s;
    wait_rx(10);
    node_rxd = 1'b1;
    wait_rx(38);
  endtask

  // ----------------------------------------
  // Capture
  // ----------------------------------------
  task automatic recv_frame(input int nbits, output logic [8:0] d, output logic stop);
    d = 9'h000;
    wait (txd === 1'b0);
    wait_tx(8);
    for (int i = 0; i < nbits; i++) begin
      wait_tx(16);
      d[i] = txd;
    end
    wait_tx(16);
    stop = txd;
    // Return only once the stop cell is over, so a new start is not refused
    wait_tx(8);
  endtask
endmodule // serial_node_model

// *** verification/uart_frame_check_addr_match_tb.sv ***
/*
  Self-checking bench: async mode 3 receive/transmit, framing check,
  address match, shared bit 7 and mode 0 transmit.
  Assumes the design package and the node model are compiled first.
*/
`timescale 1ns/1ps
module uart_frame_check_addr_match_tb;
  logic clk_sys = 1'b0, reset_n = 1'b0, clk_en = 1'b1, node_rxd, rxd_in;
  logic rx_tick = 1'b0, tx_tick = 1'b0, shift_tick = 1'b0, tx_start = 1'b0;
  logic rx_done_clr = 1'b0, tx_done_clr = 1'b0, bit7_wr = 1'b0, bit7_wdata = 1'b0;
  logic [7:0] tx_data = 8'h00, rx_data, b;
  logic rxd_out, rxd_oe, txd, received_ninth_bit, receive_done_flag;
  logic transmit_done_flag, framing_error_flag, serial_mode_bit0, bit7_rd, early, st, nine;
  logic [8:0] got;
  uf_pkg::serial_cfg_t cfg = '0;
  uf_pkg::addr_cfg_t addr_cfg = '0;
  int fails = 0, checked = 0, tcnt = 0;
  logic [7:0] addr_tab [4] = '{8'hf0, 8'hf3, 8'hff, 8'hfb};

  always #4 clk_sys = ~clk_sys;
  // Receive and transmit ticks at different rates
  always @(negedge clk_sys) begin
    tcnt <= tcnt + 1;
    rx_tick <= (tcnt % 3 == 0);
    tx_tick <= (tcnt % 4 == 1);
    shift_tick <= (tcnt % 2 == 0);
  end
  assign rxd_in = rxd_oe ? rxd_out : node_rxd;

  uart_frame_check_addr_match i_uart_frame_check_addr_match (.clk_sys(clk_sys),
    .reset_n(reset_n), .clk_en(clk_en), .rxd_in(rxd_in), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd(txd), .rx_tick(rx_tick), .tx_tick(tx_tick),
    .shift_tick(shift_tick), .cfg(cfg), .addr_cfg(addr_cfg), .tx_start(tx_start),
    .tx_data(tx_data), .rx_done_clr(rx_done_clr), .tx_done_clr(tx_done_clr),
    .bit7_wr(bit7_wr), .bit7_wdata(bit7_wdata), .rx_data(rx_data),
    .received_ninth_bit(received_ninth_bit), .receive_done_flag(receive_done_flag),
    .transmit_done_flag(transmit_done_flag), .framing_error_flag(framing_error_flag),
    .serial_mode_bit0(serial_mode_bit0), .bit7_rd(bit7_rd));

  serial_node_model i_serial_node_model (.clk_sys(clk_sys), .rx_tick(rx_tick),
    .tx_tick(tx_tick), .txd(txd), .node_rxd(node_rxd));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic addr_ok(input logic [7:0] v, input logic [7:0] sa,
                                   input logic [7:0] m);
    logic [7:0] bc;
    bc = sa | m;
    return (((v ^ sa) & m) == 8'h00) || (((v ^ bc) & bc) == 8'h00);
  endfunction

  task automatic pulse(ref logic sig);
    @(negedge clk_sys) sig = 1'b1;
    @(negedge clk_sys) sig = 1'b0;
  endtask

  task automatic write_bit7(input logic v);
    bit7_wdata = v;
    pulse(bit7_wr);
    @(negedge clk_sys);
  endtask

  // Early holds the done flag seen just before the stop cell
  task automatic rx_frame(input logic [7:0] v, input logic n9, input logic s);
    pulse(rx_done_clr);
    i_serial_node_model.send_bits({n9, v}, 9);
    early = receive_done_flag;
    i_serial_node_model.send_stop(s);
  endtask

  task automatic wait_txd(input logic v);
    for (int n = 0; n < 100 && txd !== v; n++) @(negedge clk_sys);
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys);
    fails++;
    end_of_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(30919));
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    check("reset flags", {receive_done_flag, transmit_done_flag, framing_error_flag,
          serial_mode_bit0, rxd_oe, txd}, 9'h001);
    cfg.serial_mode_bit1 = 1'b1;
    cfg.rx_enable = 1'b1;
    write_bit7(1'b1);
    check("mode bit0", {serial_mode_bit0, bit7_rd, framing_error_flag}, 9'h006);
    for (int i = 0; i < 4; i++) begin
      b = $urandom;
      nine = $urandom;
      rx_frame(b, nine, i[0]);
      check("early done", early, 1'b1);
      check("rx data", {received_ninth_bit, rx_data}, {nine, b});
      check("ninth bit", received_ninth_bit, nine);
      check("fe off", framing_error_flag, 1'b0);
    end
    cfg.frame_check_select = 1'b1;
    rx_frame(8'h5a, 1'b0, 1'b1);
    check("late done", {early, receive_done_flag, framing_error_flag}, 9'h002);
    rx_frame(8'ha5, 1'b1, 1'b0);
    check("fe set", {framing_error_flag, bit7_rd}, 9'h003);
    rx_frame(8'h3c, 1'b0, 1'b1);
    check("fe sticky", {framing_error_flag, rx_data}, 9'h13c);
    write_bit7(1'b0);
    check("fe clear", {framing_error_flag, serial_mode_bit0}, 9'h001);
    cfg.frame_check_select = 1'b0;
    cfg.multiproc_enable = 1'b1;
    addr_cfg.station_address = 8'hf1;
    addr_cfg.station_address_mask = 8'hfa;
    for (int i = 0; i < 8; i++) begin
      b = (i < 4) ? addr_tab[i] : 8'($urandom);
      rx_frame(b, 1'b1, 1'b1);
      check("addr hit", receive_done_flag, addr_ok(b, 8'hf1, 8'hfa));
    end
    rx_frame(8'hff, 1'b0, 1'b1);
    check("data dropped", receive_done_flag, 1'b0);
    cfg.multiproc_enable = 1'b0;
    for (int i = 0; i < 3; i++) begin
      tx_data = $urandom;
      cfg.tx_ninth = $urandom;
      b = $urandom;
      pulse(tx_done_clr);
      pulse(tx_start);
      fork
        i_serial_node_model.recv_frame(9, got, st);
        rx_frame(b, 1'b1, 1'b1);
      join
      check("tx frame", got, {cfg.tx_ninth, tx_data});
      check("tx stop", {st, transmit_done_flag}, 9'h003);
      check("rx beside tx", {receive_done_flag, rx_data}, {1'b1, b});
    end
    cfg.serial_mode_bit1 = 1'b0;
    b = $urandom;
    rx_frame(b, 1'b1, 1'b1);
    check("mode1 data", {receive_done_flag, rx_data}, {1'b1, b});
    cfg.frame_check_select = 1'b1;
    rx_frame(8'h81, 1'b0, 1'b1);
    check("mode1 fe", {receive_done_flag, framing_error_flag}, 9'h003);
    write_bit7(1'b0);
    cfg.frame_check_select = 1'b0;
    cfg.rx_enable = 1'b0;
    write_bit7(1'b0);
    tx_data = $urandom;
    pulse(tx_done_clr);
    pulse(tx_start);
    for (int i = 0; i < 8; i++) begin
      wait_txd(1'b0);
      wait_txd(1'b1);
      got[i] = rxd_out;
      check("shift oe", rxd_oe, 1'b1);
    end
    repeat (4) @(negedge clk_sys);
    check("shift data", got[7:0], tx_data);
    check("shift done", transmit_done_flag, 1'b1);
    clk_en = 1'b0;
    pulse(tx_done_clr);
    check("frozen done", transmit_done_flag, 1'b1);
    clk_en = 1'b1;
    end_of_test();
  end
endmodule // uart_frame_check_addr_match_tb
